// File: jtap_regs.vh
`ifndef JTAP_REGS_VH
`define JTAP_REGS_VH

// Controller state codes
`define JTAP_ST_RESET    4'h0
`define JTAP_ST_IDLE     4'h1
`define JTAP_ST_SEL_DR   4'h2
`define JTAP_ST_CAP_DR   4'h3
`define JTAP_ST_SH_DR    4'h4
`define JTAP_ST_EX1_DR   4'h5
`define JTAP_ST_PAU_DR   4'h6
`define JTAP_ST_EX2_DR   4'h7
`define JTAP_ST_UPD_DR   4'h8
`define JTAP_ST_SEL_IR   4'h9
`define JTAP_ST_CAP_IR   4'ha
`define JTAP_ST_SH_IR    4'hb
`define JTAP_ST_EX1_IR   4'hc
`define JTAP_ST_PAU_IR   4'hd
`define JTAP_ST_EX2_IR   4'he
`define JTAP_ST_UPD_IR   4'hf

// Instruction codes
`define JTAP_IR_WIDTH    4
`define JTAP_IR_IDCODE   4'h1
`define JTAP_IR_USER     4'h8
`define JTAP_IR_BYPASS   4'hf
`define JTAP_IR_CAPTURE  4'h1

// Consecutive TMS-high edges that force the reset state
`define JTAP_TMS_RESET_CNT 3'h5

`endif

// File: jtap_buf.v
module jtap_buf #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:1];
  reg             wr_q;
  reg             rd_q;
  reg [1:0]       cnt_q;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= {WIDTH{1'b0}};
      mem_q[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end

endmodule // jtap_buf

// File: jtap_tap.v
`include "jtap_regs.vh"

module jtap_tap #(
  parameter [31:0] ID_VALUE   = 32'h00000001,  // Arbitrary identification value, bit 0 set
  parameter        USER_WIDTH = 8
) (
  // System
  input  wire                  CLK,
  input  wire                  RST_N,
  // Test port pins
  input  wire                  TCK,
  input  wire                  TMS,
  input  wire                  TDI,
  input  wire                  TRST_N,
  output wire                  TDO,
  output wire                  TDO_OE,
  // Status towards the functional logic
  output wire                  TEST_ACTIVE,
  output wire [3:0]            TAP_STATE,
  output wire [3:0]            INSTR,
  // Words shifted in through the user register
  output wire                  USER_VALID,
  input  wire                  USER_READY,
  output wire [USER_WIDTH-1:0] USER_DATA
);

  localparam IRW = `JTAP_IR_WIDTH;

  // Two-flop synchronisers; stage three only serves the TCK edge finder
  reg [1:0] tck_sync_q;
  reg       tck_last_q;
  reg [1:0] tms_sync_q;
  reg [1:0] tdi_sync_q;
  reg [1:0] trst_sync_q;

  always @(posedge CLK) begin
    if (!RST_N) begin
      tck_sync_q  <= 2'h0;
      tck_last_q  <= 1'b0;
      tms_sync_q  <= 2'h3;
      tdi_sync_q  <= 2'h3;
      trst_sync_q <= 2'h3;
    end else begin
      tck_sync_q  <= {tck_sync_q[0], TCK};
      tck_last_q  <= tck_sync_q[1];
      tms_sync_q  <= {tms_sync_q[0], TMS};
      tdi_sync_q  <= {tdi_sync_q[0], TDI};
      trst_sync_q <= {trst_sync_q[0], TRST_N};
    end
  end

  wire tck_s   = tck_sync_q[1];
  wire tms_s   = tms_sync_q[1];
  wire tdi_s   = tdi_sync_q[1];
  // Test reset acts two CLK cycles after the pin falls; no TCK edge is needed
  wire trst_s  = ~trst_sync_q[1];
  // TCK held low gives no edge, so every register below except push_q just keeps its value; push_q still clears once the buffer has room
  wire tck_ris = tck_s && !tck_last_q;
  wire tck_fal = !tck_s && tck_last_q;

  reg  [3:0]            st_q;
  reg  [3:0]            st_d;
  reg  [2:0]            ones_q;
  reg  [IRW-1:0]        ir_q;
  reg  [IRW-1:0]        ir_sh_q;
  reg  [31:0]           dr_sh_q;
  reg                   tdo_q;
  reg                   tdo_oe_q;
  reg                   push_q;
  reg  [USER_WIDTH-1:0] push_data_q;
  wire                  buf_in_ready;

  // The shift states gate both TDI sampling and the TDO driver
  wire in_sh_ir = (st_q == `JTAP_ST_SH_IR);
  wire in_sh_dr = (st_q == `JTAP_ST_SH_DR);
  wire in_shift = in_sh_ir || in_sh_dr;
  wire tdo_bit  = in_sh_ir ? ir_sh_q[0] : dr_sh_q[0];

  // Unknown codes fall back to the one-bit bypass path
  wire sel_id   = (ir_q == `JTAP_IR_IDCODE);
  wire sel_user = (ir_q == `JTAP_IR_USER);
  wire sel_byp  = !sel_id && !sel_user;

  always @* begin
    st_d = `JTAP_ST_RESET;
    case (st_q)
      `JTAP_ST_RESET:  st_d = tms_s ? `JTAP_ST_RESET  : `JTAP_ST_IDLE;
      `JTAP_ST_IDLE:   st_d = tms_s ? `JTAP_ST_SEL_DR : `JTAP_ST_IDLE;
      `JTAP_ST_SEL_DR: st_d = tms_s ? `JTAP_ST_SEL_IR : `JTAP_ST_CAP_DR;
      `JTAP_ST_CAP_DR: st_d = tms_s ? `JTAP_ST_EX1_DR : `JTAP_ST_SH_DR;
      `JTAP_ST_SH_DR:  st_d = tms_s ? `JTAP_ST_EX1_DR : `JTAP_ST_SH_DR;
      `JTAP_ST_EX1_DR: st_d = tms_s ? `JTAP_ST_UPD_DR : `JTAP_ST_PAU_DR;
      `JTAP_ST_PAU_DR: st_d = tms_s ? `JTAP_ST_EX2_DR : `JTAP_ST_PAU_DR;
      `JTAP_ST_EX2_DR: st_d = tms_s ? `JTAP_ST_UPD_DR : `JTAP_ST_SH_DR;
      `JTAP_ST_UPD_DR: st_d = tms_s ? `JTAP_ST_SEL_DR : `JTAP_ST_IDLE;
      `JTAP_ST_SEL_IR: st_d = tms_s ? `JTAP_ST_RESET  : `JTAP_ST_CAP_IR;
      `JTAP_ST_CAP_IR: st_d = tms_s ? `JTAP_ST_EX1_IR : `JTAP_ST_SH_IR;
      `JTAP_ST_SH_IR:  st_d = tms_s ? `JTAP_ST_EX1_IR : `JTAP_ST_SH_IR;
      `JTAP_ST_EX1_IR: st_d = tms_s ? `JTAP_ST_UPD_IR : `JTAP_ST_PAU_IR;
      `JTAP_ST_PAU_IR: st_d = tms_s ? `JTAP_ST_EX2_IR : `JTAP_ST_PAU_IR;
      `JTAP_ST_EX2_IR: st_d = tms_s ? `JTAP_ST_UPD_IR : `JTAP_ST_SH_IR;
      `JTAP_ST_UPD_IR: st_d = tms_s ? `JTAP_ST_SEL_DR : `JTAP_ST_IDLE;
      default:         st_d = `JTAP_ST_RESET;
    endcase
  end

  // The graph already reaches reset in five; the run counter guards against a corrupt state
  wire       tms_run_done = tms_s && (ones_q + 3'h1 >= `JTAP_TMS_RESET_CNT);
  wire [3:0] st_nx        = tms_run_done ? `JTAP_ST_RESET : st_d;

  // Run of TMS-high rises, saturating at the reset count
  always @(posedge CLK) begin
    if (!RST_N || trst_s) begin
      ones_q <= 3'h0;
    end else if (tck_ris) begin
      if (!tms_s)
        ones_q <= 3'h0;
      else if (ones_q != `JTAP_TMS_RESET_CNT)
        ones_q <= ones_q + 3'h1;
    end
  end

  // Controller and instruction register
  always @(posedge CLK) begin
    if (!RST_N || trst_s) begin
      st_q    <= `JTAP_ST_RESET;
      ir_q    <= `JTAP_IR_IDCODE;
      ir_sh_q <= {IRW{1'b0}};
    end else if (tck_ris) begin
      st_q <= st_nx;
      case (st_q)
        `JTAP_ST_CAP_IR: ir_sh_q <= `JTAP_IR_CAPTURE;
        `JTAP_ST_SH_IR:  ir_sh_q <= {tdi_s, ir_sh_q[IRW-1:1]};
        `JTAP_ST_UPD_IR: ir_q    <= ir_sh_q;
        default:         ir_q    <= ir_q;
      endcase
      // Every way into the reset state, TMS alone too, restores the identification instruction
      if (st_nx == `JTAP_ST_RESET)
        ir_q <= `JTAP_IR_IDCODE;
    end
  end

  // A word updated while the previous one still waits is dropped; poll bit 0 first
  wire user_upd = (st_q == `JTAP_ST_UPD_DR) && sel_user && !push_q;

  // Data register path; bit 0 of the user capture shows buffer room
  always @(posedge CLK) begin
    if (!RST_N || trst_s) begin
      dr_sh_q     <= 32'h00000000;
      push_q      <= 1'b0;
      push_data_q <= {USER_WIDTH{1'b0}};
    end else begin
      if (push_q && buf_in_ready)
        push_q <= 1'b0;
      if (tck_ris) begin
        if (st_q == `JTAP_ST_CAP_DR) begin
          if (sel_id)
            dr_sh_q <= ID_VALUE;
          else if (sel_user)
            dr_sh_q <= {31'h00000000, buf_in_ready};
          else
            dr_sh_q <= 32'h00000000;
        end else if (in_sh_dr) begin
          if (sel_byp)
            dr_sh_q[0] <= tdi_s;
          else if (sel_user)
            dr_sh_q[USER_WIDTH-1:0] <= {tdi_s, dr_sh_q[USER_WIDTH-1:1]};
          else
            dr_sh_q <= {tdi_s, dr_sh_q[31:1]};
        end else if (user_upd) begin
          push_q      <= 1'b1;
          push_data_q <= dr_sh_q[USER_WIDTH-1:0];
        end
      end
    end
  end

  // TDO moves on the falling edge so the controller samples it stable at the next rise
  always @(posedge CLK) begin
    if (!RST_N || trst_s) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fal) begin
      tdo_oe_q <= in_shift;
      tdo_q    <= tdo_bit;
    end
  end

  // The buffer keeps its words through a test reset; only the system reset empties it
  jtap_buf #(
    .WIDTH (USER_WIDTH)
  ) u_buf (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (push_q),
    .in_ready  (buf_in_ready),
    .in_data   (push_data_q),
    .out_valid (USER_VALID),
    .out_ready (USER_READY),
    .out_data  (USER_DATA)
  );

  assign TDO         = tdo_q;
  assign TDO_OE      = tdo_oe_q;
  assign TEST_ACTIVE = (st_q != `JTAP_ST_RESET);
  assign TAP_STATE   = st_q;
  assign INSTR       = ir_q;

endmodule // jtap_tap

// File: jtap_tap_props.sv
`include "jtap_regs.vh"

module jtap_tap_props #(
  parameter USER_WIDTH = 8
) (
  input wire                  CLK,
  input wire                  RST_N,
  input wire                  TCK,
  input wire                  TMS,
  input wire                  TDI,
  input wire                  TRST_N,
  input wire                  TDO,
  input wire                  TDO_OE,
  input wire                  TEST_ACTIVE,
  input wire [3:0]            TAP_STATE,
  input wire [3:0]            INSTR,
  input wire                  USER_VALID,
  input wire                  USER_READY,
  input wire [USER_WIDTH-1:0] USER_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  reg       tck_q;
  reg [2:0] ones_q;
  // Counts TMS-high rises at the pin, saturating so the check fires once per run of ones
  always @(posedge CLK) begin
    tck_q <= TCK;
    if (!RST_N || !TRST_N)
      ones_q <= 3'h0;
    else if (TCK && !tck_q)
      ones_q <= !TMS ? 3'h0 : (ones_q == 3'h5) ? ones_q : ones_q + 3'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  oe_in_shift_a: assert property (TDO_OE |-> TAP_STATE inside {`JTAP_ST_SH_DR, `JTAP_ST_SH_IR,
    `JTAP_ST_EX1_DR, `JTAP_ST_EX1_IR}) else $error("TDO driven outside shift");
  oe_on_fall_a: assert property ($changed(TDO_OE) |-> !TCK && !$past(TCK))
    else $error("TDO enable moved while TCK high");
  tdo_on_fall_a: assert property ($changed(TDO) |-> !TCK && !tck_q)
    else $error("TDO moved while TCK high");
  active_state_a: assert property (TEST_ACTIVE == (TAP_STATE != `JTAP_ST_RESET))
    else $error("test active does not match state");
  reset_idcode_a: assert property (TAP_STATE == `JTAP_ST_RESET |-> INSTR == `JTAP_IR_IDCODE)
    else $error("reset state without identification instruction");
  trst_reset_a: assert property (!TRST_N [*5] |-> TAP_STATE == `JTAP_ST_RESET && INSTR == `JTAP_IR_IDCODE)
    else $error("test reset not applied");
  state_on_rise_a: assert property ($changed(TAP_STATE) |-> $past(TCK) || $past(TCK, 2) || !$past(TRST_N))
    else $error("state moved without a TCK rise");
  instr_update_a: assert property ($changed(INSTR) |-> $past(TAP_STATE) == `JTAP_ST_UPD_IR ||
    TAP_STATE == `JTAP_ST_RESET) else $error("instruction moved outside update");
  tms_five_a: assert property (ones_q == 3'h5 && $past(ones_q) == 3'h4 |-> ##[0:8] TAP_STATE == `JTAP_ST_RESET)
    else $error("five TMS ones did not reset");
  word_hold_a: assert property (USER_VALID && !USER_READY |=> USER_VALID && $stable(USER_DATA))
    else $error("user word lost under stall");
  cover property (INSTR == `JTAP_IR_BYPASS);
  cover property (USER_VALID && USER_READY);
  cover property (ones_q == 3'h5);
  cover property (TDO_OE);
endmodule // jtap_tap_props

bind jtap_tap jtap_tap_props #(.USER_WIDTH(USER_WIDTH)) i_jtap_tap_props (.CLK, .RST_N, .TCK, .TMS, .TDI,
  .TRST_N, .TDO, .TDO_OE, .TEST_ACTIVE, .TAP_STATE, .INSTR, .USER_VALID, .USER_READY, .USER_DATA);

// File: jtap_ctl_model.sv
module jtap_ctl_model (
  input  wire CLK,
  input  wire TDO,
  input  wire TDO_OE,
  output reg  TCK,
  output reg  TMS,
  output reg  TDI
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b1;
  end
  // Low 5 CLK, high 3 CLK: 200 ns; returns one edge after the fall so the rise's effects have settled
  task cyc(input logic tms, input logic tdi, output logic tdo);
    TMS <= tms;
    TDI <= tdi;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    tdo = TDO_OE ? TDO : ~TDO;
    @(posedge CLK);
    TCK <= 1'b1;
    repeat (3) @(posedge CLK);
    TCK <= 1'b0;
    @(posedge CLK);
  endtask
endmodule // jtap_ctl_model

// File: jtap_tap_tb_top.sv
`include "jtap_regs.vh"

module jtap_tap_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] ID_VAL = 32'h5a3c0e61; // Arbitrary value, bit 0 set
  logic        CLK = 1'b0;
  logic        RST_N, TRST_N, USER_READY, t;
  wire         TCK, TMS, TDI, TDO, TDO_OE, TEST_ACTIVE, USER_VALID;
  wire  [3:0]  TAP_STATE, INSTR;
  wire  [7:0]  USER_DATA;
  logic [31:0] d;
  int          fails = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #12.5 CLK = ~CLK;
  jtap_tap #(.ID_VALUE(ID_VAL), .USER_WIDTH(8)) i_jtap_tap (.CLK, .RST_N, .TCK, .TMS, .TDI, .TRST_N, .TDO,
    .TDO_OE, .TEST_ACTIVE, .TAP_STATE, .INSTR, .USER_VALID, .USER_READY, .USER_DATA);
  jtap_ctl_model i_jtap_ctl_model (.CLK, .TDO, .TDO_OE, .TCK, .TMS, .TDI);
  task finish_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails = fails + 1;
      finish_test;
    end
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cy(input logic tms);
    i_jtap_ctl_model.cyc(tms, 1'b1, t);
  endtask
  // Starts and ends in idle; bits go LSB first
  task scan(input logic ir, input int n, input logic [31:0] din);
    d = '0;
    cy(1'b1);
    if (ir)
      cy(1'b1);
    cy(1'b0);
    cy(1'b0);
    for (int i = 0; i < n; i++) begin
      i_jtap_ctl_model.cyc(i == n - 1, din[i], t);
      d[i] = t;
    end
    cy(1'b1);
    cy(1'b0);
  endtask
  task t_user;
    logic [7:0] w [3];
    w = '{8'ha5, 8'h3c, 8'h81};
    scan(1'b1, 4, `JTAP_IR_USER);
    chk("ir capture", `JTAP_IR_CAPTURE, d[3:0]);
    chk("instr user", `JTAP_IR_USER, INSTR);
    // The receiver stalls, so the third word waits for room
    for (int k = 0; k < 3; k++) begin
      scan(1'b0, 8, w[k]);
      chk("room bit", k < 2, d[0]);
    end
    for (int k = 0; k < 3; k++) begin
      for (int n = 0; USER_VALID !== 1'b1 && n < 20; n++)
        @(negedge CLK);
      chk("user valid", 1'b1, USER_VALID);
      chk("user word", w[k], USER_DATA);
      @(posedge CLK) USER_READY <= 1'b1;
      @(posedge CLK) USER_READY <= 1'b0;
      @(negedge CLK);
    end
    chk("user drained", 1'b0, USER_VALID);
  endtask
  task t_bypass;
    scan(1'b1, 4, 32'hf);
    chk("instr bypass", `JTAP_IR_BYPASS, INSTR);
    scan(1'b0, 4, 32'hb);
    chk("bypass out", 32'h6, d);
  endtask
  task t_stop;
    repeat (60) @(posedge CLK);
    chk("state stopped", `JTAP_ST_IDLE, TAP_STATE);
    chk("oe idle", 1'b0, TDO_OE);
  endtask
  task t_trst;
    cy(1'b1);
    TRST_N <= 1'b0;
    repeat (6) @(posedge CLK);
    chk("trst state", `JTAP_ST_RESET, TAP_STATE);
    chk("trst instr", `JTAP_IR_IDCODE, INSTR);
    TRST_N <= 1'b1;
    repeat (3) @(posedge CLK);
  endtask
  task t_tms5;
    cy(1'b0);
    scan(1'b1, 4, 32'hf);
    chk("tms5 bypass", `JTAP_IR_BYPASS, INSTR);
    cy(1'b1);
    cy(1'b0);
    cy(1'b0);
    repeat (5) cy(1'b1);
    chk("tms5 state", `JTAP_ST_RESET, TAP_STATE);
    chk("tms5 active", 1'b0, TEST_ACTIVE);
    chk("tms5 instr", `JTAP_IR_IDCODE, INSTR);
  endtask
  initial begin
    RST_N = 1'b0;
    TRST_N = 1'b1;
    USER_READY = 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("reset state", `JTAP_ST_RESET, TAP_STATE);
    chk("reset instr", `JTAP_IR_IDCODE, INSTR);
    chk("reset active", 1'b0, TEST_ACTIVE);
    cy(1'b0);
    scan(1'b0, 32, 32'h0);
    chk("idcode", ID_VAL, d);
    t_user;
    t_bypass;
    t_stop;
    t_trst;
    t_tms5;
    finish_test;
  end
endmodule // jtap_tap_tb_top
